// ---- inc/fru_pkg.sv ----
package fru_pkg;

  // Operation codes
  typedef enum logic [3:0] {
    OP_ADD  = 4'h0,
    OP_SUB  = 4'h1,
    OP_MUL  = 4'h2,
    OP_DIV  = 4'h3,
    OP_CMP  = 4'h4,
    OP_MIN  = 4'h5,
    OP_MAX  = 4'h6,
    OP_SQRT = 4'h7,
    OP_F2I  = 4'h8,
    OP_I2F  = 4'h9,
    OP_D2S  = 4'hA,
    OP_S2D  = 4'hB
  } fru_op_t;

  // Operand classes
  localparam logic [1:0] C_ZERO = 2'h0;
  localparam logic [1:0] C_NORM = 2'h1;
  localparam logic [1:0] C_EXC  = 2'h2;

  // Flag positions in the flag field
  localparam int F_ILL = 0;
  localparam int F_NEG = 1;
  localparam int F_DZ  = 2;
  localparam int F_IOV = 3;
  localparam int F_OVF = 4;
  localparam int F_UNF = 5;

  // Format constants
  localparam logic [7:0]         SP_EXP_ONES = 8'hFF;
  localparam logic signed [11:0] SP_BIAS     = 12'sh07F;
  localparam logic signed [11:0] DP_BIAS     = 12'sh3FF;
  localparam logic signed [11:0] SP_EXP_TOP  = 12'sh0FF;
  localparam logic signed [11:0] INT_TOP     = 12'sh01F;
  localparam logic [31:0]        SP_FIXED_NAN_RESULT     = 32'hFF800001;
  localparam logic [63:0]        DP_FIXED_NAN_RESULT     = 64'hFFF0000000000001;
  localparam logic [31:0]        SP_INF      = 32'h7F800000;

  // Whole state of the unit
  typedef struct packed {
    logic [63:0] result;
    logic [5:0]  flg;
    logic        lt;
    logic        eq;
    logic        done;
  } fru_state_t;

  localparam fru_state_t RST_STATE = '0;

endpackage

// ---- tb/fru_status_word.sv ----
`timescale 1ns/1ps
module fru_status_word
  import fru_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Completion from the unit
  input  wire logic       done,
  input  wire logic [5:0] flg,
  // Accumulated status
  output logic [5:0]      sticky
);
  // Status word keeps every flag seen since reset
  always_ff @(posedge clk) begin
    if (rst) begin
      sticky <= 6'h00;
    end else if (done) begin
      sticky <= sticky | flg;
    end
  end
endmodule

// ---- tb/fru_unit_tb.sv ----
`timescale 1ns/1ps
module fru_unit_tb;
  import fru_pkg::*;
  logic        clk, rst, start, done, cmp_lt, cmp_eq;
  fru_op_t     op;
  logic [63:0] opa, opb, result;
  logic        ill, neg, dz, iov, ovf, unf;
  logic [5:0]  sticky;
  int          n_mismatch, cmp_count;

  fru_unit dut (.clk(clk), .rst(rst), .start(start), .op(op), .opa(opa), .opb(opb),
    .result(result), .done(done), .cmp_lt(cmp_lt), .cmp_eq(cmp_eq),
    .illegal_operand_flag(ill), .neg_root_flag(neg), .div_by_zero_flag(dz),
    .int_overflow_flag(iov), .fp_overflow_flag(ovf), .fp_underflow_flag(unf));
  fru_status_word sw (.clk(clk), .rst(rst), .done(done),
    .flg({unf, ovf, iov, dz, neg, ill}), .sticky(sticky));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One request, answer expected at the next falling edge
  task automatic rund(input fru_op_t o, input logic [63:0] a, b, r, input logic [5:0] f);
    int i;
    @(negedge clk);
    start = 1'b1;
    op = o;
    opa = a;
    opb = b;
    @(negedge clk);
    start = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 4) begin
      @(negedge clk);
      i++;
    end
    if (i == 4) begin
      n_mismatch++;
      $display("CHECK FAILED done expected 1 seen 0");
      wrap_up();
    end
    chk("latency", 64'h0, 64'(i));
    chk("result", r, result);
    chk("flags", {58'h0, f}, {58'h0, unf, ovf, iov, dz, neg, ill});
  endtask

  task automatic run(input fru_op_t o, input logic [31:0] a, b, r, input logic [5:0] f);
    rund(o, {32'h0, a}, {32'h0, b}, {32'h0, r}, f);
  endtask

  task automatic cmpr(input logic [31:0] a, b, input logic lt, eq, input logic [5:0] f);
    run(OP_CMP, a, b, 32'h40000000, f);
    chk("lt", {63'h0, lt}, {63'h0, cmp_lt});
    chk("eq", {63'h0, eq}, {63'h0, cmp_eq});
  endtask

  task automatic t_reset;
    chk("idle result", 64'h0, result);
    chk("flags", 64'h0, {55'h0, done, ill, neg, dz, iov, ovf, unf, cmp_lt, cmp_eq});
    chk("idle status", 64'h0, {58'h0, sticky});
    $display("test reset done");
  endtask

  task automatic t_add;
    run(OP_ADD, 32'h3F800000, 32'h3F800000, 32'h40000000, 6'h00);
    run(OP_ADD, 32'h3F800000, 32'h33A00000, 32'h3F800001, 6'h00);
    run(OP_ADD, 32'h3F800000, 32'h33800000, 32'h3F800000, 6'h00);
    run(OP_SUB, 32'h3F800001, 32'h3F800000, 32'h34000000, 6'h00);
    run(OP_ADD, 32'h3F800000, 32'h3FC00000, 32'h40200000, 6'h00);
    run(OP_SUB, 32'h80800001, 32'h80800000, 32'h00000000, 6'h20);
    run(OP_SUB, 32'h40000000, 32'h40000000, 32'h00000000, 6'h00);
    run(OP_ADD, 32'h80000000, 32'h80000001, 32'h00000000, 6'h00);
    run(OP_ADD, 32'h80000001, 32'hC0000000, 32'hC0000000, 6'h00);
    run(OP_ADD, 32'hFF7FFFFF, 32'hFF7FFFFF, 32'hFF800000, 6'h10);
    run(OP_ADD, 32'h7F800000, 32'h3F800000, 32'hFF800001, 6'h01);
    run(OP_SUB, 32'h3F800000, 32'h7FC00000, 32'hFF800001, 6'h01);
    $display("test add done");
  endtask

  task automatic t_cmp;
    run(OP_ADD, 32'h3F800000, 32'h3F800000, 32'h40000000, 6'h00);
    cmpr(32'h3F800000, 32'h40000000, 1'b1, 1'b0, 6'h00);
    cmpr(32'h7F7FFFFF, 32'h7F7FFFFF, 1'b0, 1'b1, 6'h00);
    cmpr(32'h7F7FFFFF, 32'hFF7FFFFF, 1'b0, 1'b0, 6'h00);
    cmpr(32'h00000000, 32'h80000001, 1'b0, 1'b1, 6'h00);
    cmpr(32'h7F800000, 32'h00000000, 1'b0, 1'b0, 6'h01);
    $display("test compare done");
  endtask

  task automatic t_mul;
    run(OP_MUL, 32'h40000000, 32'h40400000, 32'h40C00000, 6'h00);
    run(OP_MUL, 32'h80000000, 32'h3F800000, 32'h80000000, 6'h00);
    run(OP_MUL, 32'hBF800000, 32'h00000001, 32'h80000000, 6'h00);
    run(OP_MUL, 32'h80000001, 32'h80000000, 32'h00000000, 6'h00);
    run(OP_MUL, 32'hFF000000, 32'h7F000000, 32'hFF800000, 6'h10);
    run(OP_MUL, 32'h80800000, 32'h00800000, 32'h80000000, 6'h20);
    run(OP_MUL, 32'h7F800000, 32'h00000000, 32'hFF800001, 6'h01);
    $display("test multiply done");
  endtask

  task automatic t_div;
    run(OP_DIV, 32'h40C00000, 32'h40000000, 32'h40400000, 6'h00);
    run(OP_DIV, 32'h3F800000, 32'h00000000, 32'h7F800000, 6'h04);
    run(OP_DIV, 32'hBF800000, 32'h00000001, 32'hFF800000, 6'h04);
    run(OP_DIV, 32'h00000000, 32'h80000000, 32'hFF800001, 6'h04);
    run(OP_DIV, 32'h7F800000, 32'h00000000, 32'hFF800001, 6'h05);
    run(OP_DIV, 32'h7FC00000, 32'h3F800000, 32'hFF800001, 6'h01);
    run(OP_DIV, 32'h80000000, 32'h3F800000, 32'h80000000, 6'h00);
    run(OP_DIV, 32'h7F000000, 32'h00800000, 32'h7F800000, 6'h10);
    run(OP_DIV, 32'h80800000, 32'h7F000000, 32'h80000000, 6'h20);
    $display("test divide done");
  endtask

  task automatic t_mm;
    run(OP_MIN, 32'h3F800000, 32'h40000000, 32'h3F800000, 6'h00);
    run(OP_MAX, 32'h3F800000, 32'h40000000, 32'h40000000, 6'h00);
    run(OP_MIN, 32'h80000001, 32'h3F800000, 32'h00000000, 6'h00);
    run(OP_MAX, 32'hBF800000, 32'h80000000, 32'h00000000, 6'h00);
    run(OP_MIN, 32'hBF800000, 32'h80000000, 32'hBF800000, 6'h00);
    run(OP_MAX, 32'h3F800000, 32'h7FC00000, 32'hFF800001, 6'h01);
    $display("test minmax done");
  endtask

  task automatic t_sqrt;
    run(OP_SQRT, 32'h40800000, 32'h0, 32'h40000000, 6'h00);
    run(OP_SQRT, 32'hC0800000, 32'h0, 32'h40000000, 6'h02);
    run(OP_SQRT, 32'h80000001, 32'h0, 32'h00000000, 6'h00);
    run(OP_SQRT, 32'h7F800000, 32'h0, 32'hFF800001, 6'h01);
    $display("test root done");
  endtask

  task automatic t_conv;
    run(OP_F2I, 32'hC0400000, 32'h0, 32'hFFFFFFFD, 6'h00);
    run(OP_F2I, 32'h3FC00000, 32'h0, 32'h00000001, 6'h00);
    run(OP_F2I, 32'h4F800001, 32'h0, 32'h00000200, 6'h08);
    run(OP_F2I, 32'hCF000000, 32'h0, 32'h80000000, 6'h00);
    run(OP_F2I, 32'h00000001, 32'h0, 32'h00000000, 6'h00);
    run(OP_F2I, 32'h7F800000, 32'h0, 32'h00000000, 6'h09);
    run(OP_I2F, 32'hFFFFFFFD, 32'h0, 32'hC0400000, 6'h00);
    run(OP_I2F, 32'h00000000, 32'h0, 32'h00000000, 6'h00);
    rund(OP_D2S, 64'h3FF0000000000000, 64'h0, 64'h3F800000, 6'h00);
    rund(OP_D2S, 64'hFFE0000000000000, 64'h0, 64'hFF800000, 6'h10);
    rund(OP_D2S, 64'h8010000000000000, 64'h0, 64'h80000000, 6'h20);
    rund(OP_D2S, 64'h0000000000000001, 64'h0, 64'h00000000, 6'h00);
    rund(OP_D2S, 64'h7FF8000000000000, 64'h0, 64'hFF800001, 6'h01);
    rund(OP_S2D, 64'h7F7FFFFF, 64'h0, 64'h47EFFFFFE0000000, 6'h00);
    rund(OP_S2D, 64'h7F800000, 64'h0, 64'hFFF0000000000001, 6'h01);
    $display("test convert done");
  endtask

  task automatic t_b2b;
    @(negedge clk);
    start = 1'b1;
    op = OP_ADD;
    opa = 64'h3F800000;
    opb = 64'h3F800000;
    @(negedge clk);
    op = OP_MUL;
    opb = 64'h3F000000;
    chk("first", 64'h40000000, result);
    @(negedge clk);
    op = fru_op_t'(4'hF);
    chk("second", 64'h3F000000, result);
    @(negedge clk);
    start = 1'b0;
    chk("third", 64'h0, {result[63:1], done ^ 1'b1});
    @(negedge clk);
    chk("done", 64'h0, {63'h0, done});
    $display("test backtoback done");
  endtask

  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst = 1'b1;
    start = 1'b0;
    op = OP_ADD;
    opa = 64'h0;
    opb = 64'h0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_add();
    t_cmp();
    t_mul();
    t_div();
    t_mm();
    t_sqrt();
    t_conv();
    t_b2b();
    chk("status", 64'h3F, {58'h0, sticky});
    run(OP_DIV, 32'h3F800000, 32'h0, 32'h7F800000, 6'h04);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    wrap_up();
  end
endmodule

// ---- verilog/fru_unit.sv ----
// Function
// RULE_01: Compare returns only status; flags as add, never overflow or underflow.
// RULE_02: Infinity or NaN operand of add, sub, mul, min/max gives illegal flag and NaN.
// RULE_03: Fixed NaN is sign 1, exponent all ones, fraction one in bit 0.
// RULE_04: Add with zero/denormal: both give +0, else the normalized operand, no flags.
// RULE_05: Multiply and divide zero results carry the XOR of operand signs.
// RULE_06: Exponent overflow returns signed infinity and sets the overflow flag.
// RULE_07: Add of normals returns the normalized sum; underflow gives +0 and underflow flag.
// RULE_08: Multiply with zero operand gives signed zero; product underflow sets only underflow.
// RULE_09: Divide by zero/denormal sets divide flag; normal numerator gives infinity, else NaN.
// RULE_10: Divide with infinity or NaN gives NaN, illegal flag, plus divide flag if needed.
// RULE_11: Min/max treats zero and denormal as +0 and raises no flags for them.
// RULE_12: Root of negative normal sets negative-root flag and returns root of magnitude.
// RULE_13: Root of zero gives zero; infinity or NaN gives NaN and illegal flag.
// RULE_14: Float-to-integer overflow sets integer overflow and returns the low 32 bits.
// RULE_15: Float-to-integer of zero gives 0; infinity or NaN sets illegal and integer overflow.
// RULE_16: Integer-to-float gives normal or zero and never raises a flag.
// RULE_17: Float-to-float overflow or underflow only when narrowing; zero converts to zero.
// RULE_18: Float-to-float of infinity or NaN sets illegal and gives NaN in target format.
// RULE_19: Add widens fractions with overflow, hidden, guard, round and sticky bits.
// RULE_20: Smaller operand shifts right by exponent difference; lost ones stay in sticky for differences up to 52.
// RULE_21: Exceptions skip the adder; zero sum gets exponent zero without normalising.
// RULE_22: Carry out shifts right folding round into sticky; cancellation shifts left.
// RULE_23: Denormal or zero operand counts as true zero without hidden bit.
// RULE_24: Rounded result is renormalized and its exponent adjusted.
// RULE_25: All six flags come with the result in the same completion cycle.
`timescale 1ns/1ps
module fru_unit
  import fru_pkg::*;
(
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // Operation request
  input  wire logic    start,
  input  wire fru_op_t op,
  input  wire logic [63:0] opa,
  input  wire logic [63:0] opb,
  // Result and compare status
  output logic [63:0]  result,
  output logic         done,
  output logic         cmp_lt,
  output logic         cmp_eq,
  // Exception flags
  output logic         illegal_operand_flag,
  output logic         neg_root_flag,
  output logic         div_by_zero_flag,
  output logic         int_overflow_flag,
  output logic         fp_overflow_flag,
  output logic         fp_underflow_flag
);

  fru_state_t r;
  fru_state_t nx;

  // Operand class from exponent extremes
  function automatic logic [1:0] cls(input logic ones, input logic zero);
    if (ones) return C_EXC;
    if (zero) return C_ZERO;
    return C_NORM;
  endfunction

  // Leading zero count of a nonzero word
  function automatic logic [4:0] lzc32(input logic [31:0] x);
    logic [4:0] n;
    n = 5'd0;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) n = 5'(31 - i);
    end
    return n;
  endfunction

  // Signed compare, zeros already folded to +0
  function automatic logic fp_lt(input logic [31:0] x, input logic [31:0] y);
    if (x[31] != y[31]) return x[31];
    return x[31] ? (x[30:0] > y[30:0]) : (x[30:0] < y[30:0]);
  endfunction

  // Round, renormalize and pack single; returns {ovf, unf, value}
  function automatic logic [33:0] pack_sp(input logic sg, input logic zs,
      input logic signed [11:0] e, input logic [23:0] m, input logic [2:0] grs);
    logic [24:0]        mr;
    logic signed [11:0] ef;
    mr = {1'b0, m} + 25'(grs[2] & (grs[1] | grs[0] | m[0]));
    ef = e;
    if (mr[24]) begin // RULE_24
      mr = mr >> 1;
      ef = e + 12'sd1;
    end
    if (ef >= SP_EXP_TOP) return {2'b10, sg, SP_INF[30:0]}; // RULE_06
    if (ef <= 12'sd0) return {2'b01, zs, 31'h0};
    return {2'b00, sg, ef[7:0], mr[22:0]};
  endfunction

  // Bitwise restoring square root; returns {root, remainder nonzero}
  function automatic logic [26:0] isqrt(input logic [51:0] x);
    logic [28:0] rm;
    logic [28:0] t;
    logic [25:0] q;
    rm = 29'h0;
    q = 26'h0;
    for (int i = 25; i >= 0; i--) begin
      rm = {rm[26:0], x[2*i+1 -: 2]};
      t = rm - {1'b0, q, 2'b01};
      if (!t[28]) begin
        rm = t;
        q = {q[24:0], 1'b1};
      end else begin
        q = {q[24:0], 1'b0};
      end
    end
    return {q, rm != 29'h0};
  endfunction

  // Operand decode
  logic [31:0] a32;
  logic [31:0] b32;
  logic [1:0]  ca;
  logic [1:0]  cb;
  logic [1:0]  cd;
  logic        xs;
  logic [31:0] za;
  logic [31:0] zb;

  always_comb begin
    a32 = opa[31:0];
    b32 = opb[31:0];
    ca = cls(&a32[30:23], ~|a32[30:23]);
    cb = cls(&b32[30:23], ~|b32[30:23]);
    cd = cls(&opa[62:52], ~|opa[62:52]);
    xs = a32[31] ^ b32[31];
    za = (ca == C_ZERO) ? 32'h0 : a32; // RULE_11
    zb = (cb == C_ZERO) ? 32'h0 : b32;
  end

  // Add and subtract datapath
  logic               sb_eff;
  logic               eff_sub;
  logic [31:0]        big;
  logic [31:0]        sml;
  logic [7:0]         ediff;
  logic [53:0]        al_sh;
  logic [27:0]        fa;
  logic [27:0]        fb;
  logic [27:0]        fsum;
  logic [27:0]        fn;
  logic [4:0]         nl;
  logic signed [11:0] esum;
  logic [33:0]        add_pk;

  always_comb begin
    sb_eff = b32[31] ^ (op == OP_SUB);
    if (b32[30:0] > a32[30:0]) begin
      big = {sb_eff, b32[30:0]};
      sml = a32;
    end else begin
      big = a32;
      sml = {sb_eff, b32[30:0]};
    end
    eff_sub = big[31] ^ sml[31];
    ediff = big[30:23] - sml[30:23];
    fa = {2'b01, big[22:0], 3'b000}; // RULE_19
    al_sh = {2'b01, sml[22:0], 29'h0} >> ((ediff > 8'd53) ? 8'd53 : ediff); // RULE_20
    fb = {al_sh[53:27], |al_sh[26:0]}; // RULE_20
    fsum = eff_sub ? (fa - fb) : (fa + fb); // RULE_21
    esum = 12'(big[30:23]);
    nl = 5'd0;
    fn = fsum;
    if (fsum[27]) begin // RULE_22
      fn = {1'b0, fsum[27:2], fsum[1] | fsum[0]};
      esum = esum + 12'sd1;
    end else if (eff_sub && fsum != 28'h0) begin // RULE_22
      nl = lzc32({fsum[26:1], 6'h0});
      fn = {1'b0, 26'(fsum[26:1] << nl), fsum[0]};
      esum = esum - 12'(nl);
    end
    add_pk = pack_sp(big[31], 1'b0, esum, fn[26:3], fn[2:0]); // RULE_07
  end

  // Multiply, divide and square root datapaths
  logic [47:0]        mprod;
  logic signed [11:0] mexp;
  logic [33:0]        mul_pk;
  logic [49:0]        dquo;
  logic signed [11:0] dexp;
  logic [33:0]        div_pk;
  logic signed [11:0] sexp;
  logic [51:0]        srad;
  logic [26:0]        sq;
  logic [33:0]        sqr_pk;

  always_comb begin
    mprod = {1'b1, a32[22:0]} * {1'b1, b32[22:0]};
    mexp = 12'(a32[30:23]) + 12'(b32[30:23]) - SP_BIAS;
    mul_pk = mprod[47]
      ? pack_sp(xs, xs, mexp + 12'sd1, mprod[47:24], {mprod[23:22], |mprod[21:0]})
      : pack_sp(xs, xs, mexp, mprod[46:23], {mprod[22:21], |mprod[20:0]});
    dquo = {1'b1, a32[22:0], 26'h0} / {26'h0, 1'b1, b32[22:0]};
    dexp = 12'(a32[30:23]) - 12'(b32[30:23]) + SP_BIAS;
    div_pk = dquo[26]
      ? pack_sp(xs, xs, dexp, dquo[26:3], {dquo[2:1], 1'b0})
      : pack_sp(xs, xs, dexp - 12'sd1, dquo[25:2], {dquo[1:0], 1'b0});
    sexp = 12'(a32[30:23]) - SP_BIAS;
    srad = sexp[0] ? {1'b1, a32[22:0], 28'h0} : {2'b01, a32[22:0], 27'h0};
    sq = isqrt(srad);
    sqr_pk = pack_sp(1'b0, 1'b0, (sexp >>> 1) + SP_BIAS, sq[26:3], sq[2:0]); // RULE_12
  end

  // Conversion datapaths
  logic signed [11:0] iexp;
  logic [63:0]        i64;
  logic [31:0]        ires;
  logic               iovf;
  logic [31:0]        iabs;
  logic [4:0]         il;
  logic [31:0]        inrm;
  logic [33:0]        i2f_pk;
  logic [33:0]        nar_pk;
  logic [10:0]        wexp;

  always_comb begin
    iexp = 12'(a32[30:23]) - SP_BIAS;
    if (iexp < 12'sd0) begin
      i64 = 64'h0;
    end else if (iexp >= 12'sd23) begin
      i64 = {40'h0, 1'b1, a32[22:0]} << 7'(iexp - 12'sd23);
    end else begin
      i64 = {40'h0, 1'b1, a32[22:0]} >> 5'(12'sd23 - iexp);
    end
    ires = a32[31] ? (32'h0 - i64[31:0]) : i64[31:0]; // RULE_14
    iovf = (iexp > INT_TOP) ||
           (iexp == INT_TOP && !(a32[31] && a32[22:0] == 23'h0));
    iabs = a32[31] ? (32'h0 - a32) : a32;
    il = lzc32(iabs);
    inrm = iabs << il;
    i2f_pk = pack_sp(a32[31], 1'b0, SP_BIAS + INT_TOP - 12'(il), inrm[31:8],
                     {inrm[7:6], |inrm[5:0]});
    nar_pk = pack_sp(opa[63], opa[63], 12'(opa[62:52]) - DP_BIAS + SP_BIAS,
                     {1'b1, opa[51:29]}, {opa[28:27], |opa[26:0]});
    wexp = 11'(12'(a32[30:23]) - SP_BIAS + DP_BIAS);
  end

  // Result and flag selection
  always_comb begin
    nx = r;
    nx.done = start;
    if (start) begin
      nx.result = 64'h0;
      nx.flg = 6'h0; // RULE_25
      nx.lt = 1'b0;
      nx.eq = 1'b0;
      case (op)
        OP_ADD, OP_SUB: begin
          if (ca == C_EXC || cb == C_EXC) begin // RULE_02
            nx.result = {32'h0, SP_FIXED_NAN_RESULT}; // RULE_03
            nx.flg[F_ILL] = 1'b1;
          end else if (ca == C_ZERO && cb == C_ZERO) begin // RULE_23
            nx.result = 64'h0; // RULE_04
          end else if (ca == C_ZERO) begin
            nx.result = {32'h0, sb_eff, b32[30:0]}; // RULE_04
          end else if (cb == C_ZERO) begin
            nx.result = {32'h0, a32}; // RULE_04
          end else if (fsum == 28'h0) begin
            nx.result = 64'h0; // RULE_21
          end else begin
            nx.result = {32'h0, add_pk[31:0]}; // RULE_07
            nx.flg[F_OVF] = add_pk[33]; // RULE_06
            nx.flg[F_UNF] = add_pk[32]; // RULE_07
          end
        end
        OP_CMP: begin
          nx.result = r.result; // RULE_01
          if (ca == C_EXC || cb == C_EXC) begin
            nx.flg[F_ILL] = 1'b1; // RULE_01
          end else begin
            nx.lt = fp_lt(za, zb);
            nx.eq = (za == zb);
          end
        end
        OP_MIN, OP_MAX: begin
          if (ca == C_EXC || cb == C_EXC) begin // RULE_02
            nx.result = {32'h0, SP_FIXED_NAN_RESULT};
            nx.flg[F_ILL] = 1'b1;
          end else if (fp_lt(za, zb) == (op == OP_MIN)) begin
            nx.result = {32'h0, za}; // RULE_11
          end else begin
            nx.result = {32'h0, zb}; // RULE_11
          end
        end
        OP_MUL: begin
          if (ca == C_EXC || cb == C_EXC) begin // RULE_02
            nx.result = {32'h0, SP_FIXED_NAN_RESULT};
            nx.flg[F_ILL] = 1'b1;
          end else if (ca == C_ZERO || cb == C_ZERO) begin
            nx.result = {32'h0, xs, 31'h0}; // RULE_08
          end else begin
            nx.result = {32'h0, mul_pk[31:0]}; // RULE_05
            nx.flg[F_OVF] = mul_pk[33]; // RULE_06
            nx.flg[F_UNF] = mul_pk[32]; // RULE_08
          end
        end
        OP_DIV: begin
          nx.flg[F_DZ] = (cb == C_ZERO); // RULE_09
          if (ca == C_EXC || cb == C_EXC) begin // RULE_10
            nx.result = {32'h0, SP_FIXED_NAN_RESULT};
            nx.flg[F_ILL] = 1'b1;
          end else if (cb == C_ZERO) begin // RULE_09
            nx.result = (ca == C_NORM) ? {32'h0, xs, SP_INF[30:0]} : {32'h0, SP_FIXED_NAN_RESULT};
          end else if (ca == C_ZERO) begin
            nx.result = {32'h0, xs, 31'h0}; // RULE_05
          end else begin
            nx.result = {32'h0, div_pk[31:0]};
            nx.flg[F_OVF] = div_pk[33]; // RULE_06
            nx.flg[F_UNF] = div_pk[32];
          end
        end
        OP_SQRT: begin
          if (ca == C_EXC) begin // RULE_13
            nx.result = {32'h0, SP_FIXED_NAN_RESULT};
            nx.flg[F_ILL] = 1'b1;
          end else if (ca == C_NORM) begin
            nx.result = {32'h0, sqr_pk[31:0]}; // RULE_13
            nx.flg[F_NEG] = a32[31]; // RULE_12
          end
        end
        OP_F2I: begin
          if (ca == C_EXC) begin // RULE_15
            nx.flg[F_ILL] = 1'b1;
            nx.flg[F_IOV] = 1'b1;
          end else if (ca == C_NORM) begin
            nx.result = {32'h0, ires}; // RULE_14
            nx.flg[F_IOV] = iovf; // RULE_14
          end
        end
        OP_I2F: begin
          if (a32 != 32'h0) nx.result = {32'h0, i2f_pk[31:0]}; // RULE_16
        end
        OP_D2S: begin
          if (cd == C_EXC) begin // RULE_18
            nx.result = {32'h0, SP_FIXED_NAN_RESULT};
            nx.flg[F_ILL] = 1'b1;
          end else if (cd == C_NORM) begin
            nx.result = {32'h0, nar_pk[31:0]}; // RULE_17
            nx.flg[F_OVF] = nar_pk[33]; // RULE_06
            nx.flg[F_UNF] = nar_pk[32]; // RULE_17
          end
        end
        OP_S2D: begin
          if (ca == C_EXC) begin // RULE_18
            nx.result = DP_FIXED_NAN_RESULT;
            nx.flg[F_ILL] = 1'b1;
          end else if (ca == C_NORM) begin
            nx.result = {a32[31], wexp, a32[22:0], 29'h0}; // RULE_17
          end
        end
        default: begin
          nx.result = 64'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= RST_STATE;
    end else begin
      r <= nx;
    end
  end

  // Outputs straight from the state register
  assign result               = r.result;
  assign done                 = r.done;
  assign cmp_lt               = r.lt;
  assign cmp_eq               = r.eq;
  assign illegal_operand_flag = r.flg[F_ILL];
  assign neg_root_flag        = r.flg[F_NEG];
  assign div_by_zero_flag     = r.flg[F_DZ];
  assign int_overflow_flag    = r.flg[F_IOV];
  assign fp_overflow_flag     = r.flg[F_OVF];
  assign fp_underflow_flag    = r.flg[F_UNF];

  // Checks
  property p_done;
    @(posedge clk) disable iff (rst) start |=> done ##1 (done == $past(start));
  endproperty
  a_done: assert property (p_done) else $error("Completion not one cycle after start"); // RULE_25

  property p_cmp;
    @(posedge clk) disable iff (rst)
      start && op == OP_CMP |=> !fp_overflow_flag && !fp_underflow_flag && $stable(result);
  endproperty
  a_cmp: assert property (p_cmp) else $error("Compare changed result or range flag"); // RULE_01

  property p_nan;
    @(posedge clk) disable iff (rst)
      start && (op == OP_ADD || op == OP_MUL) && ca == C_EXC
      |=> illegal_operand_flag && result == {32'h0, SP_FIXED_NAN_RESULT};
  endproperty
  a_nan: assert property (p_nan) else $error("Exception operand not fixed NaN"); // RULE_02 RULE_03

  property p_addz;
    @(posedge clk) disable iff (rst)
      start && op == OP_ADD && ca == C_ZERO && cb == C_ZERO
      |=> result == 64'h0 && !fp_underflow_flag;
  endproperty
  a_addz: assert property (p_addz) else $error("Zero plus zero not positive zero"); // RULE_04

  property p_addun;
    @(posedge clk) disable iff (rst)
      start && op == OP_ADD ##1 fp_underflow_flag |-> result == 64'h0 && !fp_overflow_flag;
  endproperty
  a_addun: assert property (p_addun) else $error("Add underflow not positive zero"); // RULE_07

  property p_mulz;
    @(posedge clk) disable iff (rst)
      start && op == OP_MUL && ca == C_ZERO && cb != C_EXC
      |=> result[30:0] == 31'h0 && result[31] == $past(xs) && !illegal_operand_flag;
  endproperty
  a_mulz: assert property (p_mulz) else $error("Multiply zero sign wrong"); // RULE_05 RULE_08

  property p_divz;
    @(posedge clk) disable iff (rst)
      start && op == OP_DIV && cb == C_ZERO && ca == C_NORM
      |=> div_by_zero_flag && !illegal_operand_flag && result[30:0] == SP_INF[30:0];
  endproperty
  a_divz: assert property (p_divz) else $error("Divide by zero not infinity"); // RULE_09

  property p_divx;
    @(posedge clk) disable iff (rst)
      start && op == OP_DIV && ca == C_EXC && cb == C_ZERO
      |=> illegal_operand_flag && div_by_zero_flag;
  endproperty
  a_divx: assert property (p_divx) else $error("Divide exception flags missing"); // RULE_10

  property p_sqn;
    @(posedge clk) disable iff (rst)
      start && op == OP_SQRT && ca == C_NORM && a32[31] |=> neg_root_flag && !result[31];
  endproperty
  a_sqn: assert property (p_sqn) else $error("Negative root flag or sign wrong"); // RULE_12

  property p_f2ix;
    @(posedge clk) disable iff (rst)
      start && op == OP_F2I && ca == C_EXC |=> illegal_operand_flag && int_overflow_flag;
  endproperty
  a_f2ix: assert property (p_f2ix) else $error("Float-to-integer exception flags"); // RULE_15

  property p_i2f;
    @(posedge clk) disable iff (rst) start && op == OP_I2F |=> r.flg == 6'h0;
  endproperty
  a_i2f: assert property (p_i2f) else $error("Integer-to-float raised a flag"); // RULE_16

  property p_s2d;
    @(posedge clk) disable iff (rst)
      start && op == OP_S2D |=> !fp_overflow_flag && !fp_underflow_flag;
  endproperty
  a_s2d: assert property (p_s2d) else $error("Widening conversion raised range flag"); // RULE_17

endmodule
